// ### hw/rimm_irq_mask_mode.v
`timescale 1ns/1ns
`include "rimm_regs.vh"
// Summary of operation
// (R1) Mask bit enables the output slip error interrupt; reset value 0 blocks it.
// (R2) Mask register two bits 7:1 read as zero; bit 0 holds the mask.
// (R3) Mode one holds sub-code change, lock loss, sub-code CRC 2-bit trigger fields.
// (R4) Mode one bits 1:0 select buffer transfer trigger: rise, fall, level.
// (R5) Mode two holds channel status CRC, parity, validity, biphase trigger fields.
// (R6) Software never writes reserved code 11; device response is undefined.
// (R7) Slip error counts only when receiver output feeds a slave-mode serial port.
// (R8) Slip error trigger sensitivity comes from a separate third mode register.
module rimm_irq_mask_mode #(
   parameter NSRC = 8
) (
   input wire clk,
   input wire sys_rst,
   input wire regWrEn,
   input wire regRdEn,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   output reg [7:0] regRdData,
   input wire [NSRC-1:0] srcEvent,
   input wire outputSlipError,
   input wire portASourced,
   input wire portASlave,
   input wire portBSourced,
   input wire portBSlave,
   output reg [NSRC-1:0] srcTrig,
   output reg slipTrig
);

   // =====================================================
   // Configuration registers
   reg slipErrorIrqEnable_q;
   reg slipErrorIrqEnable_d;
   reg [7:0] modeOne_q;
   reg [7:0] modeOne_d;
   reg [7:0] modeTwo_q;
   reg [7:0] modeTwo_d;
   reg [1:0] slipErrorTriggerMode_q;
   reg [1:0] slipErrorTriggerMode_d;
   wire wrMaskTwo;
   wire wrModeOne;
   wire wrModeTwo;
   wire wrModeThree;
   wire [2*NSRC-1:0] srcModes;

   // Each source owns the 2-bit field at bits 2i+1:2i of the joined mode registers.
   assign srcModes = {modeTwo_q, modeOne_q};

   // Writes to any other address are dropped, so stray host traffic cannot disturb the modes.
   assign wrMaskTwo = regWrEn & (regAddr == `RIMM_ADDR_MASK_TWO);
   assign wrModeOne = regWrEn & (regAddr == `RIMM_ADDR_MODE_ONE);
   assign wrModeTwo = regWrEn & (regAddr == `RIMM_ADDR_MODE_TWO);
   assign wrModeThree = regWrEn & (regAddr == `RIMM_ADDR_MODE_THREE);

   // (R1) slip mask write
   always @* begin
      slipErrorIrqEnable_d = slipErrorIrqEnable_q;
      if (wrMaskTwo) begin
         slipErrorIrqEnable_d = regWrData[`RIMM_MASK_SLIP_BIT];
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         slipErrorIrqEnable_q <= `RIMM_RST_MASK;
      end else begin
         slipErrorIrqEnable_q <= slipErrorIrqEnable_d;
      end
   end

   // (R3) (R4) mode one fields
   always @* begin
      modeOne_d = modeOne_q;
      if (wrModeOne) begin
         modeOne_d = regWrData;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         modeOne_q <= {4{`RIMM_RST_MODE}};
      end else begin
         modeOne_q <= modeOne_d;
      end
   end

   // (R5) mode two fields
   always @* begin
      modeTwo_d = modeTwo_q;
      if (wrModeTwo) begin
         modeTwo_d = regWrData;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         modeTwo_q <= {4{`RIMM_RST_MODE}};
      end else begin
         modeTwo_q <= modeTwo_d;
      end
   end

   // (R8) slip trigger mode
   always @* begin
      slipErrorTriggerMode_d = slipErrorTriggerMode_q;
      if (wrModeThree) begin
         slipErrorTriggerMode_d = regWrData[`RIMM_MODE3_SLIP_MSB:`RIMM_MODE3_SLIP_LSB];
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         slipErrorTriggerMode_q <= `RIMM_RST_MODE;
      end else begin
         slipErrorTriggerMode_q <= slipErrorTriggerMode_d;
      end
   end

   // =====================================================
   // Read-back
   // The read value holds between reads, so the host may pick it up late.
   reg [7:0] regRdData_d;

   always @* begin
      regRdData_d = regRdData;
      if (regRdEn) begin
         case (regAddr)
            // (R2) upper bits zero
            `RIMM_ADDR_MASK_TWO: regRdData_d = {7'h00, slipErrorIrqEnable_q};
            `RIMM_ADDR_MODE_ONE: regRdData_d = modeOne_q;
            `RIMM_ADDR_MODE_TWO: regRdData_d = modeTwo_q;
            `RIMM_ADDR_MODE_THREE: regRdData_d = {6'h00, slipErrorTriggerMode_q};
            default: regRdData_d = `RIMM_RST_RDATA;
         endcase
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         regRdData <= `RIMM_RST_RDATA;
      end else begin
         regRdData <= regRdData_d;
      end
   end

   // =====================================================
   // Event history
   // The previous samples follow the inputs even in reset, so a source that is already
   // high when reset ends is not mistaken for a fresh rising edge.
   reg [NSRC-1:0] srcPrev_q;
   reg slipPrev_q;

   always @(posedge clk) begin
      srcPrev_q <= srcEvent;
      slipPrev_q <= outputSlipError;
   end

   // =====================================================
   // Trigger detection per source
   // The reserved code raises nothing, so a stray write cannot flood the receiver interrupt.
   wire [NSRC-1:0] srcTrig_d;
   genvar i;

   generate
      for (i = 0; i < NSRC; i = i + 1) begin : gSrc
         reg trigBit_d;
         wire [1:0] fieldMode;
         assign fieldMode = srcModes[2*i+1:2*i];
         // (R3) (R4) (R5) edge or level
         always @* begin
            case (fieldMode)
               `RIMM_MODE_RISE: trigBit_d = srcEvent[i] & ~srcPrev_q[i];
               `RIMM_MODE_FALL: trigBit_d = ~srcEvent[i] & srcPrev_q[i];
               `RIMM_MODE_LEVEL: trigBit_d = srcEvent[i];
               default: trigBit_d = 1'b0;
            endcase
         end
         assign srcTrig_d[i] = trigBit_d;
      end
   endgenerate

   always @(posedge clk) begin
      if (sys_rst) begin
         srcTrig <= {NSRC{1'b0}};
      end else begin
         srcTrig <= srcTrig_d;
      end
   end

   // =====================================================
   // Output slip error path
   reg slipEdge_d;
   wire slipQualified;
   wire slipTrig_d;

   // (R7) slave port qualifies
   // Port A decides whenever it is fed; port B only counts when port A is not fed.
   assign slipQualified = portASourced ? portASlave : (portBSourced & portBSlave);

   // (R8) selected sensitivity
   always @* begin
      case (slipErrorTriggerMode_q)
         `RIMM_MODE_RISE: slipEdge_d = outputSlipError & ~slipPrev_q;
         `RIMM_MODE_FALL: slipEdge_d = ~outputSlipError & slipPrev_q;
         `RIMM_MODE_LEVEL: slipEdge_d = outputSlipError;
         default: slipEdge_d = 1'b0;
      endcase
   end

   // (R1) mask gates trigger
   // A cleared mask holds the trigger low whatever the sensitivity.
   assign slipTrig_d = slipEdge_d & slipErrorIrqEnable_q & slipQualified;

   always @(posedge clk) begin
      if (sys_rst) begin
         slipTrig <= 1'b0;
      end else begin
         slipTrig <= slipTrig_d;
      end
   end

endmodule // rimm_irq_mask_mode

// ### hw/rimm_regs.vh
`ifndef RIMM_REGS_VH
`define RIMM_REGS_VH
// =====================================================
// Register addresses
`define RIMM_ADDR_MASK_TWO 8'h17
`define RIMM_ADDR_MODE_ONE 8'h18
`define RIMM_ADDR_MODE_TWO 8'h19
`define RIMM_ADDR_MODE_THREE 8'h1a
// =====================================================
// Field positions
`define RIMM_MASK_SLIP_BIT 0
`define RIMM_MODE3_SLIP_MSB 1
`define RIMM_MODE3_SLIP_LSB 0
// =====================================================
// Reset values
`define RIMM_RST_MASK 1'h0
`define RIMM_RST_MODE 2'h0
`define RIMM_RST_RDATA 8'h00
// =====================================================
// Mode encodings
`define RIMM_MODE_RISE 2'h0
`define RIMM_MODE_FALL 2'h1
`define RIMM_MODE_LEVEL 2'h2
// =====================================================
// Source indices in the event vector
`define RIMM_SRC_XFER 0
`define RIMM_SRC_SUBCRC 1
`define RIMM_SRC_LOCK 2
`define RIMM_SRC_SUBCHG 3
`define RIMM_SRC_BIPH 4
`define RIMM_SRC_VALID 5
`define RIMM_SRC_PARITY 6
`define RIMM_SRC_CSCRC 7
`endif

// ### verification/rimm_irq_mask_mode_props.sv
`timescale 1ns/1ns
module rimm_irq_props #(
   parameter NSRC = 8
) (
   input wire clk,
   input wire sys_rst,
   input wire regWrEn,
   input wire regRdEn,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire [7:0] regRdData,
   input wire [NSRC-1:0] srcEvent,
   input wire [NSRC-1:0] srcTrig,
   input wire outputSlipError,
   input wire portASourced,
   input wire portASlave,
   input wire portBSourced,
   input wire portBSlave,
   input wire slipTrig
);
   reg maskShadow_q;
   // Shadow of the slip mask, since the mask itself is not a port.
   always @(posedge clk) begin
      maskShadow_q <= sys_rst ? 1'b0 : (regWrEn && regAddr == 8'h17) ? regWrData[0] : maskShadow_q;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> srcTrig == 0 && !slipTrig && regRdData == 0)
      else $error("outputs not cleared by reset");
   mask_gate_a: assert property (!maskShadow_q |=> !slipTrig) else $error("slip trigger while masked");
   mask_upper_a: assert property (regRdEn && regAddr == 8'h17 |=> regRdData[7:1] == 7'h0)
      else $error("mask upper bits set");
   mode_back_a: assert property (regWrEn && regAddr == 8'h18 ##1 !regWrEn ##1
      regRdEn && !regWrEn && regAddr == 8'h18 |=> regRdData == $past(regWrData, 3)) else $error("mode one readback");
   mode_two_back_a: assert property (regWrEn && regAddr == 8'h19 ##1 !regWrEn ##1
      regRdEn && !regWrEn && regAddr == 8'h19 |=> regRdData == $past(regWrData, 3)) else $error("mode two readback");
   trig_cause_a: assert property (srcTrig[0] |-> $past(srcEvent[0]) || $past(srcEvent[0], 2))
      else $error("trigger without event");
   slip_qual_a: assert property (slipTrig |->
      $past((portASourced && portASlave) || (!portASourced && portBSourced && portBSlave)))
      else $error("slip trigger unqualified");
   mode3_upper_a: assert property (regRdEn && regAddr == 8'h1a |=> regRdData[7:2] == 6'h0)
      else $error("mode three upper bits set");
   cover property (slipTrig);
   cover property (srcTrig[7]);
   cover property (regRdEn && regAddr == 8'h19);
endmodule // rimm_irq_props
bind rimm_irq_mask_mode rimm_irq_props #(.NSRC(NSRC)) u_rimm_irq_props (
   .clk(clk),
   .sys_rst(sys_rst),
   .regWrEn(regWrEn),
   .regRdEn(regRdEn),
   .regAddr(regAddr),
   .regWrData(regWrData),
   .regRdData(regRdData),
   .srcEvent(srcEvent),
   .srcTrig(srcTrig),
   .outputSlipError(outputSlipError),
   .portASourced(portASourced),
   .portASlave(portASlave),
   .portBSourced(portBSourced),
   .portBSlave(portBSlave),
   .slipTrig(slipTrig)
);

// ### verification/test_rimm_irq_mask_mode.sv
`timescale 1ns/1ns
module test_rimm_irq_mask_mode;
   reg clk = 0, sys_rst = 1, regWrEn = 0, regRdEn = 0, outputSlipError = 0;
   reg portASourced = 0, portASlave = 0, portBSourced = 0, portBSlave = 0;
   reg [7:0] regAddr = 8'h0, regWrData = 8'h0, srcEvent = 8'h0;
   wire [7:0] regRdData, srcTrig;
   wire slipTrig;
   integer n_mismatch = 0, checks_done = 0;
   rimm_irq_mask_mode u_rimm_irq_mask_mode (
      .clk(clk),
      .sys_rst(sys_rst),
      .regWrEn(regWrEn),
      .regRdEn(regRdEn),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .srcEvent(srcEvent),
      .outputSlipError(outputSlipError),
      .portASourced(portASourced),
      .portASlave(portASlave),
      .portBSourced(portBSourced),
      .portBSlave(portBSlave),
      .srcTrig(srcTrig),
      .slipTrig(slipTrig)
   );
   always #50 clk = ~clk;
   task end_sim;
      if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // =====================================================
   // Host access and event stimulus
   // All tasks start and end at a falling edge; each access lets an idle edge pass,
   // so a strobe is never lowered and raised again in the same instant.
   task wr(input [7:0] a, d);
      regWrEn = 1;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWrEn = 0;
      @(negedge clk);
   endtask
   task rd(input [7:0] a, e);
      regRdEn = 1;
      regAddr = a;
      @(negedge clk);
      regRdEn = 0;
      @(negedge clk);
      chk(regRdData, e);
   endtask
   task ev(input [7:0] v, e);
      srcEvent = v;
      @(negedge clk);
      chk(srcTrig, e);
   endtask
   task slip(input v, e);
      outputSlipError = v;
      @(negedge clk);
      chk({7'h0, slipTrig}, {7'h0, e});
   endtask
   initial begin
      #100000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 0;
      rd(8'h17, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h19, 8'h00);
      rd(8'h1a, 8'h00);
      ev(8'h0f, 8'h0f);
      ev(8'h0f, 8'h00);
      ev(8'h00, 8'h00);
      wr(8'h17, 8'hff);
      rd(8'h17, 8'h01);
      // Fields from bit 0 up: level, fall, level, rise in mode one; level, fall, rise, level in mode two.
      wr(8'h18, 8'h26);
      rd(8'h18, 8'h26);
      wr(8'h19, 8'h86);
      rd(8'h19, 8'h86);
      ev(8'hff, 8'hdd);
      ev(8'hff, 8'h95);
      ev(8'h00, 8'h22);
      portASourced = 1;
      portASlave = 1;
      portBSourced = 1;
      portBSlave = 1;
      slip(1, 1);
      slip(0, 0);
      portASlave = 0;
      slip(1, 0);
      slip(0, 0);
      portASourced = 0;
      slip(1, 1);
      slip(0, 0);
      wr(8'h17, 8'h00);
      slip(1, 0);
      slip(0, 0);
      wr(8'h1a, 8'h02);
      rd(8'h1a, 8'h02);
      wr(8'h17, 8'h01);
      slip(1, 1);
      slip(1, 1);
      wr(8'h1a, 8'h01);
      slip(0, 1);
      slip(0, 0);
      // A second reset must bring the mask, mode one and mode three registers back to their defaults.
      sys_rst = 1;
      repeat (2) @(negedge clk);
      sys_rst = 0;
      rd(8'h17, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h1a, 8'h00);
      end_sim;
   end
endmodule // test_rimm_irq_mask_mode
